// ---- inc/pio_pkg.sv ----
// shared constants and types for the port io interface
package pio_pkg;
   localparam int DATA_W = 8;
   localparam int PORT_W = 8;
   localparam int NUM_PORTS = 256;
   localparam int NUM_REGS = 16;
   localparam int REG_IDX_W = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int NUM_DEST = 8;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_PORT = 8'h00;
   localparam logic [7:0] BROADCAST_PORT = 8'hff;
   localparam logic [7:0] IN_PORT_BASE = 8'h80;
   // gray coded on idle -> first -> second
   typedef enum logic [1:0] {
      PIO_IDLE = 2'b00,
      PIO_WR1 = 2'b01,
      PIO_WR2 = 2'b11,
      PIO_RD1 = 2'b10
   } pio_state_t;
endpackage

// ---- inc/pio_if.sv ----
// port bus between the processor end and the fabric end
`timescale 1ns/10ps
interface pio_if;
   logic [7:0] port_select_bus; // port address
   logic [7:0] wr_data; // write data bus
   logic [7:0] rd_data; // read data bus
   logic wr_valid; // write valid pulse
   logic rd_taken; // read taken pulse
   modport cpu (output port_select_bus, output wr_data, output wr_valid,
                output rd_taken, input rd_data);
   modport fab (input port_select_bus, input wr_data, input wr_valid,
                input rd_taken, output rd_data);
endinterface

// ---- rtl/pio_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module pio_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys, // clock
   input wire logic rst, // async reset, high
   input wire logic in_valid, // write side valid
   output logic in_ready, // write side ready
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic out_valid, // read side valid
   input wire logic out_ready, // read side ready
   output logic [WIDTH-1:0] out_data // read data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg;
   logic [AW-1:0] rp_reg;
   logic [AW:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   // honest flags from occupancy
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rp_reg];
   // storage has no reset, pointers do
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp_reg] <= in_data;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         if (pop) rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ---- rtl/pio_cpu_end.sv ----
// processor end: runs two-cycle port write and port read instructions
// Operation
// RULE1: write data comes from selected data register
// RULE2: port from register or immediate constant
// RULE3: write valid high only in second cycle
// RULE4: select and data stable both cycles
// RULE5: fabric gates decoded select with write valid
// RULE6: few destinations use one-hot port addresses
// RULE7: one-hot decode accepts broadcast addresses
// RULE8: pipelined decode flag gated next cycle
// RULE9: fabric may register data and select
// RULE10: write never waits for acknowledgement
// RULE11: read data valid by second cycle end
// RULE12: one register stage on read path
// RULE13: port select spans 256 addresses
// RULE14: read taken high only second cycle
// RULE15: read data sampled at second edge
// RULE16: both pulses low outside second cycle
`timescale 1ns/10ps
module pio_cpu_end (
   input wire logic clk_sys, // clock
   input wire logic rst, // async reset, high
   pio_if.cpu bus, // port bus
   input wire logic cmd_valid, // start an instruction
   output logic cmd_ready, // idle or cycle two, command taken
   input wire logic cmd_write, // 1 write, 0 read
   input wire logic cmd_indirect, // port from register
   input wire logic [3:0] cmd_reg, // data register, source or target
   input wire logic [3:0] cmd_addr_reg, // address_source_register index
   input wire logic [7:0] cmd_imm, // immediate port address
   input wire logic ld_valid, // load a data register
   input wire logic [3:0] ld_idx, // register to load
   input wire logic [7:0] ld_data, // value to load
   input wire logic [3:0] view_idx, // register to view
   output logic [7:0] view_data, // viewed register value
   output logic rd_done // pulse after a read lands
);

   // timing, counted from the edge that takes an instruction:
   //    cycle one: select and data newly registered, both pulses low
   //    cycle two: write valid or read taken high for one cycle
   //    edge two: read data lands in the target register
   //    edge two: the next instruction may already be taken
   // select and data never move inside an instruction, which is what
   // lets the fabric register them or pipeline its decode
   // side loads share the register file write port with reads and lose;
   // the caller must keep loads away from the second cycle of a read

   // register file, one byte per data register
   logic [7:0] regs [pio_pkg::NUM_REGS];

   // sequencer state
   pio_pkg::pio_state_t st_reg;
   pio_pkg::pio_state_t st_next;

   // operands held for both cycles of an instruction
   logic [7:0] port_reg;
   logic [7:0] wdat_reg;
   logic [3:0] tgt_reg;
   logic is_wr_reg;
   logic done_reg;

   // cycle two of either kind shares one state
   // the kind flag tells a write from a read there
   function automatic logic f_second(input pio_pkg::pio_state_t s);
      return (s == pio_pkg::PIO_WR2);
   endfunction

   // cycle one is the only window in which the kind flag may move
   function automatic logic f_first(input pio_pkg::pio_state_t s);
      return (s == pio_pkg::PIO_WR1) || (s == pio_pkg::PIO_RD1);
   endfunction

   // idle and cycle two both accept; back to back costs no bubble
   function automatic logic f_accepts(input pio_pkg::pio_state_t s);
      return (s == pio_pkg::PIO_IDLE) || f_second(s);
   endfunction

   // port source: immediate or register, full 8 bits reach 256 ports
   wire [7:0] port_pick = cmd_indirect ? regs[cmd_addr_reg] : cmd_imm; // RULE2 RULE13
   wire [7:0] data_pick = regs[cmd_reg]; // RULE1

   // a command is taken only where the sequencer accepts
   wire start = cmd_valid && cmd_ready;

   // state decodes shared by the processes below
   wire in_first = f_first(st_reg);
   wire in_second = f_second(st_reg);
   wire first_is_wr = (st_reg == pio_pkg::PIO_WR1);

   // register file write port: read data wins over side loads
   wire rf_from_bus = bus.rd_taken;
   wire rf_we = rf_from_bus || ld_valid;

   // index and value follow the winner
   wire [3:0] rf_idx = rf_from_bus ? tgt_reg : ld_idx;
   wire [7:0] rf_din = rf_from_bus ? bus.rd_data : ld_data; // RULE15 RULE11

   // ready decodes from state alone
   assign cmd_ready = f_accepts(st_reg);

   // select and data come straight from held registers
   assign bus.port_select_bus = port_reg; // RULE4
   assign bus.wr_data = wdat_reg; // RULE1 RULE4

   // pulses from state and kind flag; no acknowledge input exists
   assign bus.wr_valid = in_second && is_wr_reg; // RULE3 RULE16
   assign bus.rd_taken = in_second && !is_wr_reg; // RULE14 RULE16

   // side view and completion flag
   assign view_data = regs[view_idx];
   assign rd_done = done_reg;

   // fixed two-cycle sequence, never stalled by the fabric
   always_comb begin
      st_next = pio_pkg::PIO_IDLE;
      case (st_reg)
         pio_pkg::PIO_IDLE,
         pio_pkg::PIO_WR2: begin
            if (start) begin
               st_next = cmd_write ? pio_pkg::PIO_WR1 : pio_pkg::PIO_RD1;
            end else begin
               st_next = pio_pkg::PIO_IDLE;
            end
         end
         pio_pkg::PIO_WR1: begin
            st_next = pio_pkg::PIO_WR2; // RULE10
         end
         pio_pkg::PIO_RD1: begin
            st_next = pio_pkg::PIO_WR2;
         end
         default: begin
            st_next = pio_pkg::PIO_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_reg <= pio_pkg::PIO_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // kind flag moves only in cycle one, so cycle two reads it settled
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         is_wr_reg <= 1'b0;
      end else if (in_first) begin
         is_wr_reg <= first_is_wr;
      end
   end

   // select captured at take, held until the next take
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         port_reg <= pio_pkg::RST_PORT;
      end else if (start) begin
         port_reg <= port_pick; // RULE4
      end
   end

   // write data captured at take, held until the next take
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wdat_reg <= pio_pkg::RST_DATA;
      end else if (start) begin
         wdat_reg <= data_pick; // RULE1 RULE4
      end
   end

   // read target remembered until the read data lands
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tgt_reg <= pio_pkg::RST_DATA[3:0];
      end else if (start) begin
         tgt_reg <= cmd_reg;
      end
   end

   // completion flag one cycle after the read pulse
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= bus.rd_taken;
      end
   end

   // register file; read data lands at edge two
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < pio_pkg::NUM_REGS; i++) begin
            regs[i] <= pio_pkg::RST_DATA;
         end
      end else if (rf_we) begin
         regs[rf_idx] <= rf_din; // RULE15
      end
   end
endmodule

// ---- rtl/pio_fab_end.sv ----
// fabric end: one-hot output decode and registered fifo-backed input
`timescale 1ns/10ps
module pio_fab_end (
   input wire logic clk_sys, // clock
   input wire logic rst, // async reset, high
   pio_if.fab bus, // port bus
   output logic [7:0] dest_q [pio_pkg::NUM_DEST], // output destinations
   input wire logic [7:0] in_src [pio_pkg::NUM_DEST], // input sources
   input wire logic src_valid, // stream into fifo
   output logic src_ready, // fifo space
   input wire logic [7:0] src_data // stream word
);
   logic [7:0] psel_reg;
   logic [7:0] wdat_reg;
   logic [7:0] hit_reg;
   logic [7:0] rdat_reg;
   logic f_valid;
   logic [7:0] f_data;
   // fifo read at port_base; rd_taken acknowledges it
   wire fifo_sel = (bus.port_select_bus == pio_pkg::IN_PORT_BASE);
   // pop decodes from the registered select, stable in cycle two
   wire fifo_pop = bus.rd_taken && (psel_reg == pio_pkg::IN_PORT_BASE);
   pio_fifo #(.WIDTH(pio_pkg::DATA_W), .DEPTH(pio_pkg::FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(src_valid),
      .in_ready(src_ready),
      .in_data(src_data),
      .out_valid(f_valid),
      .out_ready(fifo_pop),
      .out_data(f_data)
   );
   // single mux then one register stage; low bits pick the source
   wire [7:0] mux_out = fifo_sel ? (f_valid ? f_data : 8'h00) : in_src[bus.port_select_bus[2:0]];
   assign bus.rd_data = rdat_reg; // RULE12 RULE11
   // pipelined decode: one-hot bits, broadcast sets several
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         psel_reg <= pio_pkg::RST_PORT;
         wdat_reg <= pio_pkg::RST_DATA;
         hit_reg <= pio_pkg::RST_PORT;
         rdat_reg <= pio_pkg::RST_DATA;
      end else begin
         psel_reg <= bus.port_select_bus; // RULE9
         wdat_reg <= bus.wr_data; // RULE9
         hit_reg <= bus.port_select_bus; // RULE6 RULE7 RULE8
         rdat_reg <= mux_out; // RULE12
      end
   end
   // capture into destinations gated by write valid
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < pio_pkg::NUM_DEST; i++) dest_q[i] <= pio_pkg::RST_DATA;
      end else begin
         for (int i = 0; i < pio_pkg::NUM_DEST; i++) begin
            if (hit_reg[i] && bus.wr_valid) dest_q[i] <= wdat_reg; // RULE5 RULE8 RULE7
         end
      end
   end
endmodule

// ---- verif/pio_sva.sv ----
// concurrent checks on the port bus between both ends
`timescale 1ns/10ps
module pio_sva (
   input wire logic clk_sys, // clock
   input wire logic rst, // async reset, high
   input wire logic [7:0] port_select_bus, // port address
   input wire logic [7:0] wr_data, // write data bus
   input wire logic [7:0] rd_data, // read data bus
   input wire logic wr_valid, // write valid pulse
   input wire logic rd_taken // read taken pulse
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // second cycle of a write: address and data unchanged from the first
   sequence wr_cycle2;
      wr_valid && $stable(port_select_bus) && $stable(wr_data);
   endsequence
   sequence rd_cycle2;
      rd_taken && $stable(port_select_bus);
   endsequence
   wr_pulse_a: assert property (wr_valid |=> !wr_valid)
      else $error("write valid longer than one cycle");
   rd_pulse_a: assert property (rd_taken |=> !rd_taken)
      else $error("read taken longer than one cycle");
   pulse_excl_a: assert property (!(wr_valid && rd_taken))
      else $error("write and read pulses together");
   wr_port_hold_a: assert property (wr_valid |-> $stable(port_select_bus))
      else $error("port moved during write");
   wr_data_hold_a: assert property (wr_valid |-> $stable(wr_data))
      else $error("write data moved during write");
   rd_port_hold_a: assert property (rd_taken |-> $stable(port_select_bus))
      else $error("port moved during read");
   wr_seq_a: assert property ($rose(wr_valid) |-> wr_cycle2 ##1 !wr_valid)
      else $error("write sequence broken");
   rd_seq_a: assert property ($rose(rd_taken) |-> rd_cycle2 ##1 !rd_taken)
      else $error("read sequence broken");
   rd_data_hold_a: assert property (rd_taken |=> $stable(rd_data))
      else $error("read data moved after read pulse");
endmodule

// ---- verif/port_io_interface_tb_top.sv ----
// self-checking bench: processor end facing fabric end over the port bus
`timescale 1ns/10ps
module port_io_interface_tb_top;
   logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_indirect = 1'b0;
   logic [3:0] cmd_reg = 4'h0, cmd_addr_reg = 4'h0, ld_idx = 4'h0, view_idx = 4'h0;
   logic [7:0] cmd_imm = 8'h00, ld_data = 8'h00, src_data = 8'h00, view_data;
   logic ld_valid = 1'b0, src_valid = 1'b0, cmd_ready, rd_done, src_ready;
   logic [7:0] dest_q [8];
   logic [7:0] src_arr [8] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
   int bad_count = 0, tests_run = 0, cycles = 0, n;
   pio_if i_pio_if ();
   pio_cpu_end i_pio_cpu_end (.clk_sys(clk_sys), .rst(rst), .bus(i_pio_if),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_indirect(cmd_indirect), .cmd_reg(cmd_reg), .cmd_addr_reg(cmd_addr_reg),
      .cmd_imm(cmd_imm), .ld_valid(ld_valid), .ld_idx(ld_idx), .ld_data(ld_data),
      .view_idx(view_idx), .view_data(view_data), .rd_done(rd_done));
   pio_fab_end i_pio_fab_end (.clk_sys(clk_sys), .rst(rst), .bus(i_pio_if),
      .dest_q(dest_q), .in_src(src_arr), .src_valid(src_valid),
      .src_ready(src_ready), .src_data(src_data));
   pio_sva i_pio_sva (.clk_sys(clk_sys), .rst(rst),
      .port_select_bus(i_pio_if.port_select_bus), .wr_data(i_pio_if.wr_data),
      .rd_data(i_pio_if.rd_data), .wr_valid(i_pio_if.wr_valid), .rd_taken(i_pio_if.rd_taken));
   always #4 clk_sys = ~clk_sys;
   // hang guard, well above the roughly ninety cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   task print_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // valid stays up afterwards so back-to-back commands assign once per step
   task cmd(input logic w, input logic ind, input logic [3:0] r, input logic [3:0] ar,
            input logic [7:0] imm);
      cmd_valid = 1'b1; cmd_write = w; cmd_indirect = ind;
      cmd_reg = r; cmd_addr_reg = ar; cmd_imm = imm;
      do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      #1;
   endtask
   task settle();
      cmd_valid = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task load(input logic [3:0] idx, input logic [7:0] val);
      ld_valid = 1'b1; ld_idx = idx; ld_data = val;
      @(posedge clk_sys);
      #1;
   endtask
   task view(input logic [3:0] idx, input logic [7:0] exp);
      @(posedge clk_sys);
      #1;
      view_idx = idx;
      #1;
      chk(view_data, exp);
   endtask
   // one-hot writes back to back, then a broadcast over all destinations
   task t_onehot();
      for (int i = 0; i < 8; i++) load(i[3:0], 8'h5a ^ i[7:0]);
      load(4'h8, 8'hc3); load(4'ha, 8'h04); load(4'hb, 8'h7e);
      ld_valid = 1'b0;
      for (int i = 0; i < 8; i++) cmd(1'b1, 1'b0, i[3:0], 4'h0, 8'h01 << i);
      settle();
      for (int i = 0; i < 8; i++) chk(dest_q[i], 8'h5a ^ i[7:0]);
      cmd(1'b1, 1'b0, 4'h8, 4'h0, 8'hff);
      cmd(1'b1, 1'b1, 4'hb, 4'ha, 8'h00);
      settle();
      for (int i = 0; i < 8; i++) chk(dest_q[i], (i == 2) ? 8'h7e : 8'hc3);
   endtask
   // direct and indirect reads from the input sources
   task t_read();
      cmd(1'b0, 1'b0, 4'hc, 4'h0, 8'h05);
      cmd(1'b0, 1'b1, 4'hd, 4'ha, 8'h00);
      settle();
      view(4'hc, 8'h35);
      view(4'hd, 8'h34);
      cmd(1'b0, 1'b0, 4'he, 4'h0, 8'h07);
      cmd_valid = 1'b0;
      chk({7'h00, rd_done}, 8'h00);
      @(posedge clk_sys);
      #1;
      chk({7'h00, rd_done}, 8'h00);
      @(posedge clk_sys);
      #1;
      chk({7'h00, rd_done}, 8'h01);
      @(posedge clk_sys);
      #1;
      chk({7'h00, rd_done}, 8'h00);
      view(4'he, 8'h37);
   endtask
   // fill the fifo until it refuses, then drain it by reads of port 80
   task t_fifo();
      n = 0;
      src_valid = 1'b1;
      for (int k = 0; k < 11; k++) begin
         src_data = 8'ha0 + n[7:0];
         @(posedge clk_sys);
         if (src_ready === 1'b1) n++;
         #1;
      end
      src_valid = 1'b0;
      chk(n[7:0], 8'h08);
      for (int i = 0; i < 9; i++) cmd(1'b0, 1'b0, i[3:0], 4'h0, 8'h80);
      settle();
      for (int i = 0; i < 9; i++) view(i[3:0], (i == 8) ? 8'h00 : 8'ha0 + i[7:0]);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      #1 rst = 1'b0;
      t_onehot();
      t_read();
      t_fifo();
      print_verdict();
   end
endmodule
